// ==== common/adcs_pkg.sv ====
// Overview of operation
// - Status bits 15 and 13..10 read zero.
// - Status bit 14 shows conversion or calibration.
// - Status bits 9..8 report power management setting.
// - Status read returns ones in bits 7..6.
// - Bit 5 shows interface mode, cleared by reads.
// - Status bit 3 reflects calibration mode.
// - Status bit 0 high while calibrating.
// - Status bits 2..1 show calibration selection.
// - Ten calibration registers, all readable and writable.
// - Calibration updates registers without host access.
// - Selection picks all, gain+offset, offset, gain.
// - Same selection decoding for reads and writes.
// - Host does not mix reads and writes.
// - Host writes control before calibration writes.
// - Read select 10 sources calibration read data.
// - Pointer resets on control write and sequence end.
// - Pointer starts at gain, except offset-only.
// - Pointer advances after each multi-register access.
// - Abandoned sequence resets on next control write.
// - Calibration reads have two zero top bits.
// - Mode 1 host completes full read sequence.
// - Status read needs select 11; reset zero.
// - Calibration word is two zeros, 14 data.
package adcs_pkg;

  // ----------------------------------------------------------------
  // Widths and calibration file layout
  // ----------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int CAL_DATA_W = 14;
  localparam int CAL_COUNT = 10;
  localparam logic [3:0] CAL_GAIN_IDX = 4'h0;
  localparam logic [3:0] CAL_OFFSET_IDX = 4'h1;
  localparam logic [3:0] CAL_DAC_FIRST = 4'h2;
  localparam logic [3:0] CAL_LAST_IDX = 4'h9;
  localparam logic [CAL_DATA_W-1:0] GAIN_RESET = 14'h2000;
  localparam logic [CAL_DATA_W-1:0] OFFSET_RESET = 14'h2000;
  localparam logic [CAL_DATA_W-1:0] DAC_RESET = 14'h0000;

  // ----------------------------------------------------------------
  // Control and status word bit positions
  // ----------------------------------------------------------------
  localparam int CTL_PM_LO = 8;
  localparam int CTL_RDSEL_LO = 6;
  localparam int CTL_MODE = 5;
  localparam int CTL_CONVST = 4;
  localparam int CTL_CAL_MODE = 3;
  localparam int CTL_CALSEL_LO = 1;
  localparam int CTL_CAL_START = 0;
  localparam int STAT_BUSY = 14;
  localparam logic [1:0] RD_CONV = 2'h0;
  localparam logic [1:0] RD_CAL = 2'h2;
  localparam logic [1:0] RD_STATUS = 2'h3;
  localparam logic [1:0] CAL_SEL_ALL = 2'h0;
  localparam logic [1:0] CAL_SEL_GAIN_OFFSET = 2'h1;
  localparam logic [1:0] CAL_SEL_OFFSET = 2'h2;
  localparam logic [1:0] CAL_SEL_GAIN = 2'h3;

  // ----------------------------------------------------------------
  // Link operations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_CTRL_WR = 2'h0,
    OP_CAL_WR = 2'h1,
    OP_READ = 2'h3
  } adcs_op_type;

  // ----------------------------------------------------------------
  // Host register map (byte offsets) and bus answers
  // ----------------------------------------------------------------
  localparam logic [3:0] HOST_CMD_OFF = 4'h0;
  localparam logic [3:0] HOST_STAT_OFF = 4'h4;
  localparam logic [3:0] HOST_RDATA_OFF = 4'h8;
  localparam int CMD_OP_LO = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Sequence decoding shared by both ends
  // ----------------------------------------------------------------
  function automatic logic [3:0] seq_first(input logic [1:0] sel);
    seq_first = (sel == CAL_SEL_OFFSET) ? CAL_OFFSET_IDX : CAL_GAIN_IDX;
  endfunction : seq_first

  function automatic logic [3:0] seq_last(input logic [1:0] sel);
    case (sel)
      CAL_SEL_ALL: seq_last = CAL_LAST_IDX;
      CAL_SEL_GAIN_OFFSET: seq_last = CAL_OFFSET_IDX;
      CAL_SEL_OFFSET: seq_last = CAL_OFFSET_IDX;
      default: seq_last = CAL_GAIN_IDX;
    endcase
  endfunction : seq_last

  function automatic logic [3:0] seq_len(input logic [1:0] sel);
    seq_len = seq_last(sel) - seq_first(sel) + 4'h1;
  endfunction : seq_len

  function automatic logic [3:0] next_ptr(input logic [1:0] sel, input logic [3:0] ptr);
    next_ptr = (ptr == seq_last(sel)) ? seq_first(sel) : ptr + 4'h1;
  endfunction : next_ptr

endpackage : adcs_pkg

// ==== common/adcs_link_if.sv ====
interface adcs_link_if import adcs_pkg::*; ();
  logic req_valid;
  logic [1:0] req_op;
  logic [WORD_W-1:0] req_data;
  logic rsp_valid;
  logic [WORD_W-1:0] rsp_data;

  modport host (
    output req_valid,
    output req_op,
    output req_data,
    input rsp_valid,
    input rsp_data
  );

  modport device (
    input req_valid,
    input req_op,
    input req_data,
    output rsp_valid,
    output rsp_data
  );
endinterface : adcs_link_if

// ==== verilog/adcs_device.sv ====
module adcs_device import adcs_pkg::*; (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  adcs_link_if.device link,
  input wire logic conv_busy,
  input wire logic [WORD_W-1:0] conv_result,
  input wire logic cal_wr_valid,
  input wire logic [3:0] cal_wr_index,
  input wire logic [CAL_DATA_W-1:0] cal_wr_data,
  input wire logic cal_finish,
  output logic conv_start,
  output logic cal_start,
  output logic [2:0] cal_kind,
  output logic [1:0] power_mgmt_bits,
  output logic interface_mode_select
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] power_mgmt_bits;
    logic [1:0] read_select;
    logic interface_mode_select;
    logic cal_mode_bit;
    logic [1:0] cal_select;
    logic cal_start_bit;
    logic [3:0] cal_ptr;
    logic [CAL_COUNT-1:0][CAL_DATA_W-1:0] cal_reg;
    logic rsp_valid;
    logic [WORD_W-1:0] rsp_data;
    logic conv_start;
    logic cal_start;
  } adcs_dev_state_type;

  adcs_dev_state_type r;
  adcs_dev_state_type next_r;

  // ----------------------------------------------------------------
  // Status word assembly
  // ----------------------------------------------------------------
  function automatic logic [WORD_W-1:0] status_word(
    input adcs_dev_state_type s,
    input logic busy
  );
    logic [WORD_W-1:0] w;
    w = '0;
    w[STAT_BUSY] = busy;
    w[CTL_PM_LO+1:CTL_PM_LO] = s.power_mgmt_bits;
    w[CTL_RDSEL_LO+1:CTL_RDSEL_LO] = RD_STATUS;
    w[CTL_MODE] = s.interface_mode_select;
    w[CTL_CAL_MODE] = s.cal_mode_bit;
    w[CTL_CALSEL_LO+1:CTL_CALSEL_LO] = s.cal_select;
    w[CTL_CAL_START] = s.cal_start_bit;
    status_word = w;
  endfunction : status_word

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.rsp_valid = 1'b0;
    next_r.conv_start = 1'b0;
    next_r.cal_start = 1'b0;

    // End of calibration; a new start in the same cycle wins below
    if (cal_finish) begin
      next_r.cal_start_bit = 1'b0;
    end

    if (link.req_valid) begin
      next_r.rsp_valid = 1'b1;
      next_r.rsp_data = '0;
      case (link.req_op)
        OP_CTRL_WR: begin
          next_r.power_mgmt_bits = link.req_data[CTL_PM_LO+1:CTL_PM_LO];
          next_r.read_select = link.req_data[CTL_RDSEL_LO+1:CTL_RDSEL_LO];
          next_r.interface_mode_select = link.req_data[CTL_MODE];
          next_r.cal_mode_bit = link.req_data[CTL_CAL_MODE];
          next_r.cal_select = link.req_data[CTL_CALSEL_LO+1:CTL_CALSEL_LO];
          next_r.cal_ptr = seq_first(next_r.cal_select);
          if (link.req_data[CTL_CAL_START]) begin
            next_r.cal_start_bit = 1'b1;
            next_r.cal_start = 1'b1;
          end
          if (link.req_data[CTL_CONVST]) begin
            next_r.conv_start = 1'b1;
          end
        end
        OP_CAL_WR: begin
          next_r.cal_reg[r.cal_ptr] = link.req_data[CAL_DATA_W-1:0];
          next_r.cal_ptr = next_ptr(r.cal_select, r.cal_ptr);
        end
        OP_READ: begin
          next_r.interface_mode_select = 1'b0;
          case (r.read_select)
            RD_STATUS: begin
              next_r.rsp_data = status_word(r, conv_busy | r.cal_start_bit);
            end
            RD_CAL: begin
              next_r.rsp_data = {2'b00, r.cal_reg[r.cal_ptr]};
              next_r.cal_ptr = next_ptr(r.cal_select, r.cal_ptr);
            end
            RD_CONV: begin
              next_r.rsp_data = conv_result;
            end
            default: begin
              next_r.rsp_data = '0;
            end
          endcase
        end
        default: begin
          next_r.rsp_data = '0;
        end
      endcase
    end

    // Calibration engine results take priority over a host write
    if (cal_wr_valid && r.cal_start_bit && (cal_wr_index <= CAL_LAST_IDX)) begin
      next_r.cal_reg[cal_wr_index] = cal_wr_data;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
      r.cal_reg[CAL_GAIN_IDX] <= GAIN_RESET;
      r.cal_reg[CAL_OFFSET_IDX] <= OFFSET_RESET;
      for (int i = CAL_DAC_FIRST; i <= CAL_LAST_IDX; i++) begin
        r.cal_reg[i] <= DAC_RESET;
      end
    end else if (ce) begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.rsp_valid = r.rsp_valid;
  assign link.rsp_data = r.rsp_data;
  assign conv_start = r.conv_start;
  assign cal_start = r.cal_start;
  assign cal_kind = {r.cal_mode_bit, r.cal_select};
  assign power_mgmt_bits = r.power_mgmt_bits;
  assign interface_mode_select = r.interface_mode_select;

endmodule : adcs_device

// ==== verilog/adcs_host.sv ====
module adcs_host import adcs_pkg::*; (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  adcs_link_if.host link,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [3:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_WAIT = 2'b01
  } adcs_host_fsm_type;

  typedef struct packed {
    adcs_host_fsm_type fsm;
    logic aw_have;
    logic [3:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] cmd;
    logic [WORD_W-1:0] last_rsp;
    logic req_valid;
    logic [1:0] req_op;
    logic [WORD_W-1:0] req_data;
    logic ctrl_seen;
    logic mode1;
    logic [1:0] rd_sel;
    logic [1:0] cal_sel;
    logic [3:0] seq_left;
    logic seq_read;
    logic locked;
  } adcs_host_state_type;

  adcs_host_state_type r;
  adcs_host_state_type next_r;
  logic [31:0] merged;
  logic [1:0] op;
  logic refuse;
  logic cal_rd;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    merged = r.cmd;
    op = 2'h0;
    refuse = 1'b0;
    cal_rd = 1'b0;
    next_r.req_valid = 1'b0;
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end
    if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end
    if (s_axi_awvalid && r.awready) begin
      next_r.aw_have = 1'b1;
      next_r.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r.wready) begin
      next_r.w_have = 1'b1;
      next_r.w_data = s_axi_wdata;
      next_r.w_strb = s_axi_wstrb;
    end

    // Link answer
    if (r.fsm == H_WAIT && link.rsp_valid) begin
      next_r.last_rsp = link.rsp_data;
      next_r.fsm = H_IDLE;
    end

    // Register write, once address and data are both held
    if (next_r.aw_have && next_r.w_have && !next_r.bvalid) begin
      for (int b = 0; b < 4; b++) begin
        if (next_r.w_strb[b]) begin
          merged[8*b +: 8] = next_r.w_data[8*b +: 8];
        end
      end
      op = merged[CMD_OP_LO+1:CMD_OP_LO];
      cal_rd = (op == OP_READ) && (r.rd_sel == RD_CAL);
      case (op)
        OP_CTRL_WR: refuse = r.locked && r.seq_left != 4'h0;
        OP_CAL_WR: refuse = !r.ctrl_seen || (r.seq_left != 4'h0 && r.seq_read);
        OP_READ: refuse = cal_rd && r.seq_left != 4'h0 && !r.seq_read;
        default: refuse = 1'b1;
      endcase
      next_r.bvalid = 1'b1;
      next_r.bresp = RESP_OKAY;
      next_r.aw_have = 1'b0;
      next_r.w_have = 1'b0;
      if (next_r.aw_addr != HOST_CMD_OFF || r.fsm != H_IDLE || refuse) begin
        next_r.bresp = RESP_SLVERR;
      end else begin
        next_r.cmd = merged;
        next_r.req_valid = 1'b1;
        next_r.req_op = op;
        next_r.req_data = merged[WORD_W-1:0];
        next_r.fsm = H_WAIT;
        if (op == OP_CTRL_WR) begin
          next_r.ctrl_seen = 1'b1;
          next_r.rd_sel = merged[CTL_RDSEL_LO+1:CTL_RDSEL_LO];
          next_r.cal_sel = merged[CTL_CALSEL_LO+1:CTL_CALSEL_LO];
          next_r.mode1 = merged[CTL_MODE];
          next_r.seq_left = 4'h0;
          next_r.locked = 1'b0;
        end else if (op == OP_CAL_WR || cal_rd) begin
          if (r.seq_left == 4'h0) begin
            next_r.seq_left = seq_len(r.cal_sel) - 4'h1;
            next_r.seq_read = cal_rd;
            next_r.locked = cal_rd && r.mode1;
          end else begin
            next_r.seq_left = r.seq_left - 4'h1;
          end
        end
        if (op == OP_READ) begin
          next_r.mode1 = 1'b0;
        end
      end
    end

    // Register read
    if (s_axi_arvalid && r.arready) begin
      next_r.rvalid = 1'b1;
      next_r.rresp = RESP_OKAY;
      case (s_axi_araddr)
        HOST_CMD_OFF: next_r.rdata = r.cmd;
        HOST_STAT_OFF: next_r.rdata = {24'h000000, r.seq_left, r.locked, r.seq_read, r.ctrl_seen,
                                       r.fsm != H_IDLE};
        HOST_RDATA_OFF: next_r.rdata = {16'h0000, r.last_rsp};
        default: begin
          next_r.rdata = 32'h00000000;
          next_r.rresp = RESP_SLVERR;
        end
      endcase
    end
    next_r.awready = !next_r.aw_have && !next_r.bvalid;
    next_r.wready = !next_r.w_have && !next_r.bvalid;
    next_r.arready = !next_r.rvalid;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign link.req_valid = r.req_valid;
  assign link.req_op = r.req_op;
  assign link.req_data = r.req_data;
  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;

endmodule : adcs_host

// ==== testbench/adcs_link_assertions.sv ====
module adcs_link_assertions import adcs_pkg::*; (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic req_valid,
  input wire logic [1:0] req_op,
  input wire logic [WORD_W-1:0] req_data,
  input wire logic rsp_valid,
  input wire logic [WORD_W-1:0] rsp_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Last control word and live mode bit seen on the link
  // ----
  logic [WORD_W-1:0] ctl;
  logic mode;
  logic rd;
  logic wr;
  assign rd = req_valid && req_op == OP_READ;
  assign wr = req_valid && req_op == OP_CTRL_WR;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctl <= 16'h0000;
      mode <= 1'b0;
    end else if (wr) begin
      ctl <= req_data;
      mode <= req_data[CTL_MODE];
    end else if (rd) begin
      mode <= 1'b0;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  chk_rsp_next_cycle: assert property (req_valid |=> rsp_valid)
    else $error("link answer late");
  chk_rsp_one_pulse: assert property (rsp_valid |=> !rsp_valid)
    else $error("link answer too long");
  chk_rsp_has_cause: assert property (rsp_valid |-> $past(req_valid))
    else $error("link answer without request");
  chk_req_gap_two: assert property (req_valid |=> !req_valid [*2])
    else $error("requests too close");
  chk_write_rsp_zero: assert property (req_valid && req_op != OP_READ |=> rsp_data == 16'h0000)
    else $error("write answer not zero");
  chk_status_fixed_bits: assert property (rd && ctl[7:6] == RD_STATUS |=>
    rsp_data[15] == 1'b0 && rsp_data[13:10] == 4'h0 && rsp_data[7:6] == 2'h3)
    else $error("status fixed bits wrong");
  chk_status_fields: assert property (rd && ctl[7:6] == RD_STATUS |=>
    rsp_data[9:8] == ctl[9:8] && rsp_data[5] == $past(mode) && rsp_data[3:1] == ctl[3:1])
    else $error("status fields wrong");
  chk_cal_top_zero: assert property (rd && ctl[7:6] == RD_CAL |=> rsp_data[15:14] == 2'h0)
    else $error("calibration word top bits set");

  cov_ctrl_write: cover property (wr ##1 rsp_valid);
  cov_status_read: cover property (rd && ctl[7:6] == RD_STATUS);
  cov_cal_read: cover property (rd && ctl[7:6] == RD_CAL);
endmodule : adcs_link_assertions

// ==== testbench/adcs_tb_top.sv ====
module adcs_tb_top import adcs_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Clock, reset and both ends
  // ----
  logic core_clk, nrst, ce, conv_busy, cal_wr_valid, cal_finish, cal_start, ims, conv_start;
  logic [15:0] conv_result;
  logic [3:0] cal_wr_index, awa, ara, ws;
  logic [13:0] cal_wr_data;
  logic [2:0] kind;
  logic [1:0] pm, bres, rres;
  logic awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  logic [31:0] wd, rd;
  int err_count, checks_done, starts, convs, cyc;

  always #10 core_clk = ~core_clk;

  adcs_link_if adcs_link_if_i ();
  adcs_device adcs_device_i (.core_clk(core_clk), .nrst(nrst), .ce(ce), .link(adcs_link_if_i),
    .conv_busy(conv_busy), .conv_result(conv_result), .cal_wr_valid(cal_wr_valid),
    .cal_wr_index(cal_wr_index), .cal_wr_data(cal_wr_data), .cal_finish(cal_finish),
    .conv_start(conv_start), .cal_start(cal_start), .cal_kind(kind), .power_mgmt_bits(pm),
    .interface_mode_select(ims));
  adcs_host adcs_host_i (.core_clk(core_clk), .nrst(nrst), .ce(ce), .link(adcs_link_if_i),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_bresp(bres), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rd), .s_axi_rresp(rres));
  adcs_link_assertions adcs_link_assertions_i (.core_clk(core_clk), .nrst(nrst),
    .req_valid(adcs_link_if_i.req_valid), .req_op(adcs_link_if_i.req_op),
    .req_data(adcs_link_if_i.req_data), .rsp_valid(adcs_link_if_i.rsp_valid),
    .rsp_data(adcs_link_if_i.rsp_data));

  always @(posedge core_clk) begin
    cyc++;
    if (cal_start === 1'b1) starts++;
    if (conv_start === 1'b1) convs++;
    if (cyc > 8000) begin
      err_count++;
      stop_test();
    end
  end

  // ----
  // Bus cycles and comparisons
  // ----
  task automatic stop_test();
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, s);
      err_count++;
    end
  endtask : chk

  task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= d;
    br <= 1'b1;
    forever begin
      @(posedge core_clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
      if (bv) break;
    end
    r = bres;
    br <= 1'b0;
  endtask : axw

  task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    arv <= 1'b1;
    ara <= a;
    rr <= 1'b1;
    forever begin
      @(posedge core_clk);
      if (arv && arr) arv <= 1'b0;
      if (rv) break;
    end
    d = rd;
    r = rres;
    rr <= 1'b0;
  endtask : axr

  task automatic do_op(input logic [1:0] op, input logic [15:0] d, input logic [1:0] er);
    logic [31:0] v;
    logic [1:0] r;
    axw(HOST_CMD_OFF, {14'h0, op, d}, r);
    chk("bresp", {30'h0, er}, {30'h0, r});
    do axr(HOST_STAT_OFF, v, r); while (v[0] !== 1'b0);
  endtask : do_op

  task automatic rd_op(input string n, input logic [15:0] e);
    logic [31:0] v;
    logic [1:0] r;
    do_op(OP_READ, 16'h0000, RESP_OKAY);
    axr(HOST_RDATA_OFF, v, r);
    chk(n, {16'h0, e}, v);
  endtask : rd_op

  function automatic logic [15:0] cv(input int i);
    cv = 16'h0101 * i[15:0];
  endfunction : cv

  task automatic t_refuse();
    logic [31:0] v;
    logic [1:0] r;
    axr(HOST_STAT_OFF, v, r);
    chk("host status", 32'h0, v);
    do_op(OP_CAL_WR, 16'h0001, RESP_SLVERR);
    axr(4'hC, v, r);
    chk("rresp", 32'h2, {30'h0, r});
  endtask : t_refuse

  task automatic t_status();
    conv_busy <= 1'b1;
    do_op(OP_CTRL_WR, 16'h02EA, RESP_OKAY);
    chk("pm", 32'h2, {30'h0, pm});
    chk("mode", 32'h1, {31'h0, ims});
    chk("kind", 32'h5, {29'h0, kind});
    rd_op("status", 16'h42EA);
    conv_busy <= 1'b0;
    rd_op("status", 16'h02CA);
    chk("mode", 32'h0, {31'h0, ims});
    do_op(OP_CTRL_WR, 16'h0010, RESP_OKAY);
    chk("convs", 32'h1, convs);
    rd_op("conv", 16'h0ABC);
  endtask : t_status

  task automatic t_file();
    for (int i = 0; i < CAL_COUNT; i++) do_op(OP_CAL_WR, 16'hC000 | cv(i), RESP_OKAY);
    do_op(OP_CTRL_WR, 16'h0080, RESP_OKAY);
    for (int i = 0; i <= CAL_COUNT; i++) rd_op("cal", cv(i % CAL_COUNT));
    do_op(OP_CTRL_WR, 16'h0080, RESP_OKAY);
    rd_op("cal", cv(0));
    rd_op("cal", cv(1));
    do_op(OP_CTRL_WR, 16'h0080, RESP_OKAY);
    rd_op("abort", cv(0));
    do_op(OP_CAL_WR, 16'h0000, RESP_SLVERR);
  endtask : t_file

  task automatic t_select();
    for (int s = 1; s < 4; s++) begin
      int first;
      int len;
      first = (s == 2) ? 1 : 0;
      len = (s == 1) ? 2 : 1;
      do_op(OP_CTRL_WR, 16'h0080 | 16'(s * 2), RESP_OKAY);
      for (int k = 0; k <= len; k++) rd_op("sel", cv(first + k % len));
    end
    do_op(OP_CTRL_WR, 16'h0004, RESP_OKAY);
    do_op(OP_CAL_WR, 16'h1234, RESP_OKAY);
    do_op(OP_CTRL_WR, 16'h0084, RESP_OKAY);
    rd_op("offset", 16'h1234);
  endtask : t_select

  task automatic t_cal();
    do_op(OP_CTRL_WR, 16'h00C9, RESP_OKAY);
    chk("starts", 32'h1, starts);
    chk("kind", 32'h4, {29'h0, kind});
    rd_op("status", 16'h40C9);
    @(posedge core_clk);
    cal_wr_valid <= 1'b1;
    cal_wr_index <= 4'h5;
    cal_wr_data <= 14'h1ABC;
    @(posedge core_clk);
    cal_wr_valid <= 1'b0;
    cal_finish <= 1'b1;
    @(posedge core_clk);
    cal_finish <= 1'b0;
    rd_op("status", 16'h00C8);
    do_op(OP_CTRL_WR, 16'h0080, RESP_OKAY);
    for (int i = 0; i < 6; i++) rd_op("engine", (i == 5) ? 16'h1ABC : (i == 1) ? 16'h1234 : cv(i));
    do_op(OP_CTRL_WR, 16'h00A0, RESP_OKAY);
    rd_op("mode1", cv(0));
    do_op(OP_CTRL_WR, 16'h0080, RESP_SLVERR);
  endtask : t_cal

  initial begin
    core_clk = 1'b0;
    nrst = 1'b0;
    ce = 1'b1;
    {conv_busy, cal_wr_valid, cal_finish, awv, wv, br, arv, rr} = 8'h00;
    {cal_wr_index, awa, ara, cal_wr_data, wd} = 58'h0;
    ws = 4'hF;
    conv_result = 16'h0ABC;
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    t_refuse();
    t_status();
    t_file();
    t_select();
    t_cal();
    stop_test();
  end
endmodule : adcs_tb_top
